// ===== core/vrts_defines.vh
`ifndef VRTS_DEFINES_VH
`define VRTS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define VRTS_OFF_REF_CTRL    8'h00
`define VRTS_OFF_CONV_CTRL   8'h04
`define VRTS_OFF_CONV_RESULT 8'h08
`define VRTS_OFF_PERIPH_FLAG 8'h0c
`define VRTS_OFF_PERIPH_EN   8'h10
`define VRTS_OFF_IRQ_CTRL    8'h14
`define VRTS_OFF_SLEEP_CTRL  8'h18

// ----------------------------------------
// Field positions: reference control
// ----------------------------------------
`define VRTS_REF_EN_BIT      7
`define VRTS_REF_RDY_BIT     6
`define VRTS_TS_EN_BIT       5
`define VRTS_TS_RNG_BIT      4
`define VRTS_GAIN_MSB        1
`define VRTS_GAIN_LSB        0

// ----------------------------------------
// Field positions: converter control
// ----------------------------------------
`define VRTS_CLKSEL_MSB      7
`define VRTS_CLKSEL_LSB      5
`define VRTS_CHSEL_MSB       4
`define VRTS_CHSEL_LSB       2
`define VRTS_GO_BIT          1
`define VRTS_CONV_ON_BIT     0

// ----------------------------------------
// Field positions: interrupts and sleep
// ----------------------------------------
`define VRTS_DONE_FLAG_BIT   6
`define VRTS_DONE_IE_BIT     6
`define VRTS_GIE_BIT         7
`define VRTS_PERIPHERAL_IRQ_ENABLE_BIT        6
`define VRTS_SLEEP_ENTER_BIT 0
`define VRTS_ASLEEP_BIT      1

// ----------------------------------------
// Reset values and fixed codes
// ----------------------------------------
`define VRTS_RST_BYTE        8'h00
`define VRTS_TEMP_CHANNEL    3'h6
`define VRTS_GAIN_OFF        2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define VRTS_CLK_MHZ         100
`define VRTS_REF_SETTLE_US   25
`define VRTS_SETTLE_CYCLES   (`VRTS_REF_SETTLE_US * `VRTS_CLK_MHZ)

`endif

// ===== core/vrts_settle.v
`timescale 1ns/10ps
`include "vrts_defines.vh"

module vrts_settle (
	// Clock and reset
	input  wire sys_clk,
	input  wire resetn,
	// Control
	input  wire enable,
	// Status
	output reg  ready
);

	// Counter only needs twelve bits; the upper bits of the count are zero
	localparam [31:0] SETTLE_LAST = `VRTS_SETTLE_CYCLES - 1;
	localparam [11:0] LAST_COUNT  = SETTLE_LAST[11:0];

	reg [11:0] count;

	// ----------------------------------------
	// Settling counter, restarts on every enable
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count <= 12'h000;
			ready <= 1'b0;
		end else if (!enable) begin
			count <= 12'h000; // R16
			ready <= 1'b0; // R16
		end else if (count == LAST_COUNT) begin
			ready <= 1'b1; // R4
		end else begin
			count <= count + 12'h001;
		end
	end

endmodule // vrts_settle

// ===== core/vrts_wake.v
`timescale 1ns/10ps

module vrts_wake (
	// Clock and reset
	input  wire sys_clk,
	input  wire resetn,
	// Requests
	input  wire sleepReq,
	input  wire wakeEvent,
	input  wire takeVector,
	input  wire nextInstrDone,
	// Status and dispatch
	output wire asleep,
	output wire wakeUp,
	output wire execNext,
	output wire vectorIsr,
	output wire resumeInline
);

	localparam [1:0] ST_RUN      = 2'b00;
	localparam [1:0] ST_SLEEP    = 2'b01;
	localparam [1:0] ST_NEXT     = 2'b10;
	localparam [1:0] ST_DISPATCH = 2'b11;

	reg [1:0] state;
	reg [1:0] next_state;

	// ----------------------------------------
	// Sleep and wake sequencing
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (sleepReq)
					next_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wakeEvent)
					next_state = ST_NEXT; // R13
			end
			ST_NEXT: begin
				if (nextInstrDone)
					next_state = ST_DISPATCH; // R14
			end
			ST_DISPATCH: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	assign asleep       = (state == ST_SLEEP);
	assign wakeUp       = (state == ST_SLEEP) && wakeEvent; // R13
	// Held until the core reports the instruction after sleep retired
	assign execNext     = (state == ST_NEXT); // R14
	assign vectorIsr    = (state == ST_DISPATCH) && takeVector; // R15
	assign resumeInline = (state == ST_DISPATCH) && !takeVector; // R15

endmodule // vrts_wake

// ===== core/vrts_top.v
// Function
// R1: Reference powered only while reference enable bit is set.
// R2: Two-bit gain select picks 1x, 2x or 4x reference amplification.
// R3: Reference buffers are off whenever the gain select field is zero.
// R4: Ready flag rises after the settling time following reference enable.
// R5: Temperature sensor powered only while its enable bit is set.
// R6: Range select one gives high range, zero gives low range; code holds low range while the sensor enable is clear.
// R7: Sensor output drives one dedicated converter input channel.
// R8: Software waits 200 us after selecting sensor before converting.
// R9: Software leaves 200 us between back-to-back sensor conversions.
// R10: Conversion done flag sets on every conversion end, regardless of enable.
// R11: Done flag stays set until software clears it; hardware never clears.
// R12: Done flag requests interrupt only when its enable bit is set.
// R13: Enabled done interrupt wakes from sleep and also fires while running.
// R14: After wake the instruction following sleep always executes first.
// R15: Wake vectors to service routine if global and peripheral enables set.
// R16: Clearing reference enable drops ready; ready returns after fresh settling.
`timescale 1ns/10ps
`include "vrts_defines.vh"

module vrts_top (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        resetn,
	// Wishbone slave
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg         wb_ack_o,
	// Converter
	input  wire        convDone,
	input  wire [7:0]  convResult,
	output wire        convStart,
	output wire        convPowerOn,
	output wire [2:0]  convClockSel,
	output wire [2:0]  convChannel,
	// Reference and sensor analog controls
	output wire        refPowerOn,
	output wire        refBufferOn,
	output wire [1:0]  refGainSel,
	output wire [2:0]  refGainFactor,
	output wire        tempSensePowerOn,
	output wire        tempRangeHigh,
	output wire        tempToConverter,
	// Interrupt and core sequencing
	output wire        irq,
	output wire        wakeUp,
	output wire        asleep,
	output wire        execNext,
	input  wire        nextInstrDone,
	output wire        vectorIsr,
	output wire        resumeInline
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:2] == off[7:2]);
		end
	endfunction

	wire busReq;
	wire busWrite;
	wire wrLow;

	assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land once, in the cycle the ack is raised
	assign busWrite = busReq && wb_we_i;
	assign wrLow    = busWrite && wb_sel_i[0];

	// ----------------------------------------
	// Register write strobes
	// ----------------------------------------
	// Only the low byte lane carries fields
	wire wrRefCtrl;
	wire wrConvCtrl;
	wire wrFlag;
	wire wrEnable;
	wire wrIrqCtrl;
	wire wrSleep;

	assign wrRefCtrl  = wrLow && hit(wb_adr_i, `VRTS_OFF_REF_CTRL);
	assign wrConvCtrl = wrLow && hit(wb_adr_i, `VRTS_OFF_CONV_CTRL);
	assign wrFlag     = wrLow && hit(wb_adr_i, `VRTS_OFF_PERIPH_FLAG);
	assign wrEnable   = wrLow && hit(wb_adr_i, `VRTS_OFF_PERIPH_EN);
	assign wrIrqCtrl  = wrLow && hit(wb_adr_i, `VRTS_OFF_IRQ_CTRL);
	assign wrSleep    = wrLow && hit(wb_adr_i, `VRTS_OFF_SLEEP_CTRL);

	// ----------------------------------------
	// Bus acknowledge
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= busReq;
	end

	// ----------------------------------------
	// Reference control register
	// ----------------------------------------
	reg       refEnable;
	reg       tempEnable;
	reg       tempRange;
	reg [1:0] gainSel;
	wire      refReady;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			refEnable  <= 1'b0;
			tempEnable <= 1'b0;
			tempRange  <= 1'b0;
			gainSel    <= `VRTS_GAIN_OFF;
		end else if (wrRefCtrl) begin
			refEnable  <= wb_dat_i[`VRTS_REF_EN_BIT];
			tempEnable <= wb_dat_i[`VRTS_TS_EN_BIT];
			tempRange  <= wb_dat_i[`VRTS_TS_RNG_BIT];
			gainSel    <= wb_dat_i[`VRTS_GAIN_MSB:`VRTS_GAIN_LSB];
		end
	end

	// ----------------------------------------
	// Settling timer
	// ----------------------------------------
	// Restarts from zero on every enable; a brief disable costs a full settle
	vrts_settle u_settle (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.enable  (refEnable),
		.ready   (refReady)
	);

	// ----------------------------------------
	// Converter control register
	// ----------------------------------------
	reg [2:0] clockSel;
	reg [2:0] channelSel;
	reg       convGo;
	reg       convOn;
	reg [7:0] result;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clockSel   <= 3'h0;
			channelSel <= 3'h0;
			convOn     <= 1'b0;
		end else if (wrConvCtrl) begin
			clockSel   <= wb_dat_i[`VRTS_CLKSEL_MSB:`VRTS_CLKSEL_LSB];
			channelSel <= wb_dat_i[`VRTS_CHSEL_MSB:`VRTS_CHSEL_LSB];
			convOn     <= wb_dat_i[`VRTS_CONV_ON_BIT];
		end
	end

	// ----------------------------------------
	// Conversion start
	// ----------------------------------------
	reg next_convGo;

	// Start bit: a software write beats the end of the old conversion
	always @* begin
		next_convGo = convGo;
		if (convDone || !convOn)
			next_convGo = 1'b0;
		if (wrConvCtrl)
			next_convGo = wb_dat_i[`VRTS_GO_BIT] && wb_dat_i[`VRTS_CONV_ON_BIT];
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			convGo <= 1'b0;
		else
			convGo <= next_convGo;
	end

	// ----------------------------------------
	// Conversion result
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			result <= `VRTS_RST_BYTE;
		else if (convDone)
			result <= convResult;
	end

	// ----------------------------------------
	// Interrupt flag, enables and control
	// ----------------------------------------
	reg doneFlag;
	reg doneIrqEnable;
	reg globalIrqEnable;
	reg periphIrqEnable;
	wire clearDone;

	assign clearDone = wrFlag && wb_dat_i[`VRTS_DONE_FLAG_BIT];

	reg next_doneFlag;

	// Set wins over a clear in the same cycle so no completion is lost
	always @* begin
		next_doneFlag = doneFlag;
		if (clearDone)
			next_doneFlag = 1'b0; // R11
		if (convDone)
			next_doneFlag = 1'b1; // R10
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			doneFlag <= 1'b0;
		else
			doneFlag <= next_doneFlag;
	end

	// ----------------------------------------
	// Interrupt enables
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			doneIrqEnable <= 1'b0;
		else if (wrEnable)
			doneIrqEnable <= wb_dat_i[`VRTS_DONE_IE_BIT];
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			globalIrqEnable <= 1'b0;
			periphIrqEnable <= 1'b0;
		end else if (wrIrqCtrl) begin
			globalIrqEnable <= wb_dat_i[`VRTS_GIE_BIT];
			periphIrqEnable <= wb_dat_i[`VRTS_PERIPHERAL_IRQ_ENABLE_BIT];
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// Level request, also high while running
	assign irq = doneFlag && doneIrqEnable; // R12 R13

	// ----------------------------------------
	// Sleep and wake
	// ----------------------------------------
	wire sleepReq;
	wire takeVector;

	assign sleepReq = wrSleep && wb_dat_i[`VRTS_SLEEP_ENTER_BIT];
	// Vector only with both enables; the wake itself needs just the masked flag
	assign takeVector = globalIrqEnable && periphIrqEnable; // R15

	vrts_wake u_wake (
		.sys_clk       (sys_clk),
		.resetn        (resetn),
		.sleepReq      (sleepReq),
		.wakeEvent     (irq),
		.takeVector    (takeVector),
		.nextInstrDone (nextInstrDone),
		.asleep        (asleep),
		.wakeUp        (wakeUp),
		.execNext      (execNext),
		.vectorIsr     (vectorIsr),
		.resumeInline  (resumeInline)
	);

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	reg [7:0] rdByte;

	always @* begin
		rdByte = `VRTS_RST_BYTE;
		if (hit(wb_adr_i, `VRTS_OFF_REF_CTRL)) begin
			rdByte[`VRTS_REF_EN_BIT]                = refEnable;
			rdByte[`VRTS_REF_RDY_BIT]               = refReady;
			rdByte[`VRTS_TS_EN_BIT]                 = tempEnable;
			rdByte[`VRTS_TS_RNG_BIT]                = tempRange;
			rdByte[`VRTS_GAIN_MSB:`VRTS_GAIN_LSB]   = gainSel;
		end else if (hit(wb_adr_i, `VRTS_OFF_CONV_CTRL)) begin
			rdByte[`VRTS_CLKSEL_MSB:`VRTS_CLKSEL_LSB] = clockSel;
			rdByte[`VRTS_CHSEL_MSB:`VRTS_CHSEL_LSB]   = channelSel;
			rdByte[`VRTS_GO_BIT]                      = convGo;
			rdByte[`VRTS_CONV_ON_BIT]                 = convOn;
		end else if (hit(wb_adr_i, `VRTS_OFF_CONV_RESULT)) begin
			rdByte = result;
		end else if (hit(wb_adr_i, `VRTS_OFF_PERIPH_FLAG)) begin
			rdByte[`VRTS_DONE_FLAG_BIT] = doneFlag;
		end else if (hit(wb_adr_i, `VRTS_OFF_PERIPH_EN)) begin
			rdByte[`VRTS_DONE_IE_BIT] = doneIrqEnable;
		end else if (hit(wb_adr_i, `VRTS_OFF_IRQ_CTRL)) begin
			rdByte[`VRTS_GIE_BIT]  = globalIrqEnable;
			rdByte[`VRTS_PERIPHERAL_IRQ_ENABLE_BIT] = periphIrqEnable;
		end else if (hit(wb_adr_i, `VRTS_OFF_SLEEP_CTRL)) begin
			rdByte[`VRTS_ASLEEP_BIT] = asleep;
		end
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	// Loaded on reads only, so the word holds for the master after ack
	// Unmapped reads return zero; upper bytes always zero
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			wb_dat_o <= 32'h00000000;
		else if (busReq && !wb_we_i)
			wb_dat_o <= {24'h000000, rdByte};
	end

	// ----------------------------------------
	// Analog control outputs
	// ----------------------------------------
	assign refPowerOn       = refEnable; // R1
	// Zero gain code doubles as the buffer power-down
	assign refBufferOn      = (gainSel != `VRTS_GAIN_OFF); // R3
	assign refGainSel       = gainSel; // R2
	assign tempSensePowerOn = tempEnable; // R5
	// Range follows the enable so a dark sensor never biases high
	assign tempRangeHigh    = tempEnable && tempRange; // R6
	// Software owns the acquisition delay before starting on this channel
	assign tempToConverter  = (channelSel == `VRTS_TEMP_CHANNEL); // R7 R8 R9

	// ----------------------------------------
	// Gain factor decode
	// ----------------------------------------
	// One-hot factor: bit0 1x, bit1 2x, bit2 4x; code zero drives none
	genvar gi;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_gain
			assign refGainFactor[gi] = ({30'h0, gainSel} == gi + 1); // R2
		end
	endgenerate

	// ----------------------------------------
	// Converter outputs
	// ----------------------------------------
	assign convStart    = convGo;
	assign convPowerOn  = convOn;
	assign convClockSel = clockSel;
	assign convChannel  = channelSel;

endmodule // vrts_top

// ===== testbench/vrts_top_assertions.sv
`timescale 1ns/10ps

module vrts_checker (
	// Clock and reset
	input wire       sys_clk,
	input wire       resetn,
	// Bus
	input wire       wb_we_i,
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	// Converter and analog
	input wire       convDone,
	input wire       convStart,
	input wire [2:0] convChannel,
	input wire [1:0] refGainSel,
	input wire [2:0] refGainFactor,
	input wire       refBufferOn,
	input wire       tempSensePowerOn,
	input wire       tempRangeHigh,
	input wire       tempToConverter,
	// Interrupt and sequencing
	input wire       irq,
	input wire       wakeUp,
	input wire       asleep,
	input wire       execNext,
	input wire       nextInstrDone,
	input wire       vectorIsr,
	input wire       resumeInline
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_gain;
		refGainFactor == ((refGainSel == 2'h0) ? 3'h0 : (3'h1 << (refGainSel - 2'h1)));
	endproperty
	a_gain: assert property (p_gain) else $error("gain factor");
	property p_buf;
		refBufferOn == (refGainSel != 2'h0);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer state");
	property p_range;
		tempRangeHigh |-> tempSensePowerOn;
	endproperty
	a_range: assert property (p_range) else $error("range while off");
	property p_chan;
		tempToConverter == (convChannel == 3'h6);
	endproperty
	a_chan: assert property (p_chan) else $error("sensor channel");
	property p_done;
		convDone && !(wb_cyc_i && wb_we_i) |=> !convStart;
	endproperty
	a_done: assert property (p_done) else $error("go not cleared");
	// Only a bus write may take the request down
	property p_hold;
		$fell(irq) |-> wb_ack_o && wb_we_i;
	endproperty
	a_hold: assert property (p_hold) else $error("flag self-cleared");
	property p_wake;
		asleep && irq |-> wakeUp ##1 execNext && !asleep;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_exec;
		wakeUp |=> execNext && !vectorIsr && !resumeInline;
	endproperty
	a_exec: assert property (p_exec) else $error("next instr skipped");
	property p_disp;
		execNext && nextInstrDone |=> vectorIsr != resumeInline;
	endproperty
	a_disp: assert property (p_disp) else $error("dispatch");
endmodule // vrts_checker

bind vrts_top vrts_checker u_chk (.sys_clk, .resetn, .wb_we_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .convDone, .convStart, .convChannel, .refGainSel, .refGainFactor,
	.refBufferOn, .tempSensePowerOn, .tempRangeHigh, .tempToConverter, .irq, .wakeUp,
	.asleep, .execNext, .nextInstrDone, .vectorIsr, .resumeInline);

// ===== testbench/vrts_conv_model.sv
`timescale 1ns/10ps

module vrts_conv_model (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       resetn,
	// Control
	input  wire       convStart,
	input  wire       convPowerOn,
	input  wire [7:0] latency,
	// Answer
	output reg        convDone,
	output reg  [7:0] convResult
);
	reg [7:0] cnt;
	reg       busy;
	reg       seen;
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			convDone <= 1'b0;
			convResult <= 8'h00;
			cnt <= 8'h00;
			busy <= 1'b0;
			seen <= 1'b0;
		end else begin
			seen <= convStart;
			convDone <= 1'b0;
			// Result is only meaningful in the done cycle
			convResult <= ~convResult;
			if (convStart && convPowerOn && !seen && !busy) begin
				busy <= 1'b1;
				cnt <= latency;
			end else if (busy && cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else if (busy) begin
				busy <= 1'b0;
				convDone <= 1'b1;
				convResult <= 8'hc3;
			end
		end
	end
endmodule // vrts_conv_model

// ===== testbench/voltage_ref_temp_sense_adc_irq_test.sv
`timescale 1ns/10ps
`include "vrts_defines.vh"

module voltage_ref_temp_sense_adc_irq_test;
	// ----
	// Signals
	// ----
	logic        sys_clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, nextInstrDone;
	logic [7:0]  wb_adr_i, convResult, latency;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic        convDone, convStart, convPowerOn, refPowerOn, refBufferOn, irq;
	logic        tempSensePowerOn, tempRangeHigh, tempToConverter, wakeUp, asleep;
	logic        execNext, vectorIsr, resumeInline;
	logic [2:0]  convChannel, refGainFactor, convClockSel;
	logic [1:0]  refGainSel;
	int          n_mismatch, samples_checked, k;
	localparam logic [7:0] RC = `VRTS_OFF_REF_CTRL;
	localparam logic [7:0] CC = `VRTS_OFF_CONV_CTRL;
	localparam logic [7:0] FL = `VRTS_OFF_PERIPH_FLAG;

	vrts_top DUT (.sys_clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_ack_o, .convDone, .convResult, .convStart, .convPowerOn,
		.convClockSel, .convChannel, .refPowerOn, .refBufferOn, .refGainSel,
		.refGainFactor, .tempSensePowerOn, .tempRangeHigh, .tempToConverter, .irq,
		.wakeUp, .asleep, .execNext, .nextInstrDone, .vectorIsr, .resumeInline);
	vrts_conv_model u_conv (.sys_clk, .resetn, .convStart, .convPowerOn, .latency,
		.convDone, .convResult);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----
	// Helpers
	// ----
	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		if (i == 20) begin
			n_mismatch++;
			summarize;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask
	task waitFor(input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge sys_clk);
			if (convDone === 1'b1) break;
		end
		if (i == n) begin
			chk(1, 0);
			summarize;
		end
	endtask
	task conv(input logic [7:0] l);
		latency <= l;
		wr(CC, 8'h19);
		repeat (20000) @(posedge sys_clk);
		wr(CC, 8'h1b);
	endtask

	// ----
	// Scenarios
	// ----
	task tReset;
		for (k = 0; k < 8; k++) rd(8'(k * 4), 0);
		chk({refPowerOn, refBufferOn, tempSensePowerOn, tempToConverter, irq}, 0);
		$display("reset done");
	endtask
	task tRef;
		for (k = 0; k < 4; k++) begin
			wr(RC, k);
			chk({refBufferOn, refGainFactor}, (k == 0) ? 0 : (8 | (1 << (k - 1))));
			chk(refGainSel, k);
			chk(refPowerOn, 0);
		end
		wr(RC, 8'h81);
		chk(refPowerOn, 1);
		repeat (2400) @(posedge sys_clk);
		rd(RC, 8'h81);
		repeat (150) @(posedge sys_clk);
		rd(RC, 8'hc1);
		wr(RC, 8'h01);
		chk(refPowerOn, 0);
		rd(RC, 8'h01);
		wr(RC, 8'h81);
		rd(RC, 8'h81);
		$display("reference done");
	endtask
	task tTemp;
		wr(RC, 8'h30);
		chk({tempSensePowerOn, tempRangeHigh}, 2'b11);
		wr(RC, 8'h20);
		chk({tempSensePowerOn, tempRangeHigh}, 2'b10);
		wr(RC, 8'h10);
		chk({tempSensePowerOn, tempRangeHigh}, 2'b00);
		for (k = 0; k < 8; k++) begin
			wr(CC, (k << 5) | (k << 2));
			chk({convClockSel, convChannel, convPowerOn}, (k << 4) | (k << 1));
			chk(tempToConverter, k == 6);
		end
		$display("sensor done");
	endtask
	task tConv;
		conv(8'h00);
		chk({convPowerOn, convStart}, 2'b11);
		waitFor(300);
		rd(CC, 8'h19);
		rd(FL, 8'h40);
		chk({irq, convStart}, 0);
		rd(`VRTS_OFF_CONV_RESULT, 8'hc3);
		wr(FL, 8'h00);
		repeat (50) @(posedge sys_clk);
		rd(FL, 8'h40);
		wr(`VRTS_OFF_PERIPH_EN, 8'h40);
		chk(irq, 1);
		wr(FL, 8'h40);
		chk(irq, 0);
		rd(FL, 8'h00);
		$display("conversion done");
	endtask
	task tSleep(input logic g);
		wr(`VRTS_OFF_IRQ_CTRL, g ? 8'hc0 : 8'h00);
		conv(8'h40);
		wr(`VRTS_OFF_SLEEP_CTRL, 8'h01);
		chk(asleep, 1);
		for (k = 0; k < 200 && wakeUp !== 1'b1; k++) @(posedge sys_clk);
		chk(k < 200, 1);
		if (k == 200) summarize;
		@(posedge sys_clk);
		chk({execNext, vectorIsr, resumeInline}, 3'b100);
		nextInstrDone <= 1'b1;
		@(posedge sys_clk);
		nextInstrDone <= 1'b0;
		@(posedge sys_clk);
		chk({vectorIsr, resumeInline}, {g, !g});
		wr(FL, 8'h40);
		$display("sleep done");
	endtask

	initial begin
		{resetn, wb_we_i, wb_cyc_i, wb_stb_i, nextInstrDone} = 5'b00000;
		{wb_adr_i, wb_dat_i, latency} = 0;
		wb_sel_i = 4'h1;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		tReset;
		tRef;
		tTemp;
		tConv;
		tSleep(1'b1);
		tSleep(1'b0);
		summarize;
	end
endmodule // voltage_ref_temp_sense_adc_irq_test
